// File: verilog/dmurf_top.sv
// Top of the 512x60 register file: captured ports, phased access and held read data.
// Notes on behaviour
// - With only write enable set, store the 60-bit word at write address in phase two.
// - With only read enable set, read entry at read address in phase one, drive output.
// - A same-address read and write is flagged and read output goes unknown.
// - While write inhibit is high, neither writes nor reads happen whatever the enables.
// - Read data is held in an output flop so the last value stays stable.
module dmurf_top
   import dmurf_pkg::*;
#(
   parameter int AW = DMURF_AW,
   parameter int DW = DMURF_DW
)
(
   input  wire logic          CLK,
   input  wire logic          SYS_RST,
   input  wire logic          CE,
   input  wire logic          RD_EN,
   input  wire logic [AW-1:0] RD_ADDR,
   input  wire logic          WR_EN,
   input  wire logic [AW-1:0] WR_ADDR,
   input  wire logic [DW-1:0] WR_DATA,
   input  wire logic          ARRAY_WR_INHIBIT,
   output logic      [DW-1:0] RD_DATA,
   output logic               COLLISION
);

   // ------------------------------------------------------------
   // Captured requests
   // ------------------------------------------------------------
   dmurf_wreq_s   wreq_r;
   dmurf_rreq_s   rreq_r;
   logic          inhibit_r;
   logic [DW-1:0] dout_r;
   logic [DW-1:0] dout_nxt;
   logic          coll_r;
   logic [DW-1:0] arr_rdata;
   logic          do_write;
   logic          do_read;
   logic          hit_same;

   // Cycle walk of one write followed by a read of the same entry: edge one
   // captures the write, and the array takes the word at edge two, which stands
   // for the second phase of the cycle that edge one opened. A read captured at
   // edge two looks at the array in the first phase of the next cycle, so it
   // already sees the word, and the held output shows it from edge three on.
   // One set of capture flops stands in for both the read-side latch and the
   // write-side flops; on a single clock each presents its request for a full
   // cycle, which is all that the array needs.

   // The edge that captures a request is the cycle start; the access then happens in
   // the cycle that edge opens, reads in its first phase and writes in its second.
   always_ff @(posedge CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         wreq_r    <= '{en: 1'b0, addr: DMURF_ADDR_RST, data: DMURF_DOUT_RST};
         rreq_r    <= '{en: 1'b0, addr: DMURF_ADDR_RST};
         inhibit_r <= 1'b0;
      end
      else if (CE)
      begin
         wreq_r    <= '{en: WR_EN, addr: WR_ADDR, data: WR_DATA};
         rreq_r    <= '{en: RD_EN, addr: RD_ADDR};
         inhibit_r <= ARRAY_WR_INHIBIT;
      end
   end

   // ------------------------------------------------------------
   // Access decode
   // ------------------------------------------------------------
   // Inhibit blocks both ports; the same-address case is detected for the collision flag.
   assign do_write = wreq_r.en && !inhibit_r;
   assign do_read  = rreq_r.en && !inhibit_r;
   assign hit_same = do_write && do_read && (wreq_r.addr == rreq_r.addr);

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   // The array writes only on a clock-enabled edge, so a frozen block cannot
   // lose or gain an entry while the surrounding logic stalls it.
   dmurf_array #(
      .ENTRIES (DMURF_ENTRIES),
      .AW      (AW),
      .DW      (DW)
   ) u_array (
      .CLK   (CLK),
      .CE    (CE),
      .WE    (do_write),
      .WADDR (wreq_r.addr),
      .WDATA (wreq_r.data),
      .RADDR (rreq_r.addr),
      .RDATA (arr_rdata)
   );

   // Phase-one read sees the array before the phase-two write of the same cycle lands.
   // A collision drives unknowns, which is simulation-only; synthesis sees a don't-care.
   always_comb
   begin
      dout_nxt = dout_r;
      if (hit_same)
         dout_nxt = 'x;
      else if (do_read)
         dout_nxt = arr_rdata;
   end

   // ------------------------------------------------------------
   // Output hold
   // ------------------------------------------------------------
   // The held value changes only on a real read, giving downstream logic a stable word.
   always_ff @(posedge CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         dout_r <= DMURF_DOUT_RST;
         coll_r <= 1'b0;
      end
      else if (CE)
      begin
         dout_r <= dout_nxt;
         coll_r <= hit_same;
      end
   end

   // Both outputs come straight from flops, so downstream logic sees no glitch.
   assign RD_DATA   = dout_r;
   assign COLLISION = coll_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   // All checks run on the core clock and are off while reset is high. Each one
   // names the clock enable at every edge it relies on, since a frozen edge
   // moves nothing forward.

   // A word written alone is seen by a read captured one edge later; a second
   // write to the same entry at that edge would collide, so it is left out.
   property p_write_store;
      @(posedge CLK) disable iff (SYS_RST)
      (CE && WR_EN && !RD_EN && !ARRAY_WR_INHIBIT)
         ##1 (CE && RD_EN && RD_ADDR == $past(WR_ADDR) && !ARRAY_WR_INHIBIT
              && !(WR_EN && WR_ADDR == RD_ADDR))
         ##1 CE
         |=> RD_DATA == $past(WR_DATA, 3);
   endproperty
   a_write_store: assert property (p_write_store)
      else $error("Written word not read back.");

   // A clean read moves the addressed word into the held output at the next edge.
   property p_read_drive;
      @(posedge CLK) disable iff (SYS_RST)
      (CE && do_read && !hit_same) |=> RD_DATA == $past(arr_rdata);
   endproperty
   a_read_drive: assert property (p_read_drive) else $error("Read data not driven.");

   // A same-entry pair raises the flag one enabled edge after its capture.
   property p_coll_flag;
      @(posedge CLK) disable iff (SYS_RST)
      (CE && RD_EN && WR_EN && RD_ADDR == WR_ADDR && !ARRAY_WR_INHIBIT) ##1 CE |=> COLLISION;
   endproperty
   a_coll_flag: assert property (p_coll_flag) else $error("Collision not flagged.");

   // An inhibited capture leaves the held word alone and never flags.
   property p_inhibit_hold;
      @(posedge CLK) disable iff (SYS_RST)
      (CE && ARRAY_WR_INHIBIT) ##1 CE |=> $stable(RD_DATA) && !COLLISION;
   endproperty
   a_inhibit_hold: assert property (p_inhibit_hold)
      else $error("Access under inhibit.");

   // Without a read the held word stays put for the downstream flop.
   property p_hold_idle;
      @(posedge CLK) disable iff (SYS_RST)
      (CE && !do_read) |=> $stable(RD_DATA);
   endproperty
   a_hold_idle: assert property (p_hold_idle) else $error("Held read data changed.");

   // Read address and write data are taken on every enabled edge.
   property p_capture;
      @(posedge CLK) disable iff (SYS_RST)
      CE |=> rreq_r.addr == $past(RD_ADDR) && wreq_r.data == $past(WR_DATA);
   endproperty
   a_capture: assert property (p_capture) else $error("Port capture wrong.");

   // The enables, write address and inhibit are taken on the same edge as the rest.
   property p_ctl_capture;
      @(posedge CLK) disable iff (SYS_RST)
      CE |=> {rreq_r.en, wreq_r.en, wreq_r.addr, inhibit_r}
             == $past({RD_EN, WR_EN, WR_ADDR, ARRAY_WR_INHIBIT});
   endproperty
   a_ctl_capture: assert property (p_ctl_capture)
      else $error("Control capture wrong.");

   // A low clock enable freezes the captured requests along with everything else.
   property p_freeze_capture;
      @(posedge CLK) disable iff (SYS_RST)
      !CE |=> $stable(rreq_r) && $stable(wreq_r) && $stable(inhibit_r);
   endproperty
   a_freeze_capture: assert property (p_freeze_capture)
      else $error("Capture moved while frozen.");

   // The held word and the flag keep their values through a frozen edge.
   property p_freeze_out;
      @(posedge CLK) disable iff (SYS_RST)
      !CE |=> $stable(RD_DATA) && $stable(COLLISION);
   endproperty
   a_freeze_out: assert property (p_freeze_out)
      else $error("Outputs moved while frozen.");

   // The flag is a one-cycle mark: no collision at an enabled edge, no flag after it.
   property p_coll_clear;
      @(posedge CLK) disable iff (SYS_RST)
      (CE && !hit_same) |=> !COLLISION;
   endproperty
   a_coll_clear: assert property (p_coll_clear)
      else $error("Collision flag stuck.");

   // An inhibited same-entry pair does no access, so it can never raise the flag.
   property p_inhibit_no_coll;
      @(posedge CLK) disable iff (SYS_RST)
      (CE && RD_EN && WR_EN && RD_ADDR == WR_ADDR && ARRAY_WR_INHIBIT) ##1 CE |=> !COLLISION;
   endproperty
   a_inhibit_no_coll: assert property (p_inhibit_no_coll)
      else $error("Collision flagged under inhibit.");

endmodule

// File: verilog/dmurf_pkg.sv
// Package with constants and carrier types for the 512x60 one-read one-write register file.
package dmurf_pkg;

   // ------------------------------------------------------------
   // Geometry and reset values
   // ------------------------------------------------------------
   localparam int          DMURF_ENTRIES  = 512;
   localparam int          DMURF_AW       = 9;
   localparam int          DMURF_DW       = 60;
   localparam logic [59:0] DMURF_DOUT_RST = 60'h0;
   localparam logic [8:0]  DMURF_ADDR_RST = 9'h000;

   // Write request as captured by the write-side flops.
   typedef struct packed
   {
      logic        en;
      logic [8:0]  addr;
      logic [59:0] data;
   } dmurf_wreq_s;

   // Read request as captured by the read-side latch.
   typedef struct packed
   {
      logic        en;
      logic [8:0]  addr;
   } dmurf_rreq_s;

endpackage

// File: verilog/dmurf_array.sv
// Flip-flop storage array with one indexed write port and one indexed read port.
module dmurf_array
   import dmurf_pkg::*;
#(
   parameter int ENTRIES = DMURF_ENTRIES,
   parameter int AW      = DMURF_AW,
   parameter int DW      = DMURF_DW
)
(
   input  wire logic          CLK,
   input  wire logic          CE,
   input  wire logic          WE,
   input  wire logic [AW-1:0] WADDR,
   input  wire logic [DW-1:0] WDATA,
   input  wire logic [AW-1:0] RADDR,
   output logic      [DW-1:0] RDATA
);

   logic [DW-1:0] mem [ENTRIES];

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   // Entries carry no reset; contents are undefined until written, as in the array.
   genvar gi;
   generate
      for (gi = 0; gi < ENTRIES; gi++)
      begin : g_entry
         always_ff @(posedge CLK)
         begin
            if (CE && WE && (WADDR == AW'(gi)))
               mem[gi] <= WDATA;
         end
      end
   endgenerate

   // Read selection is a plain index into the array.
   assign RDATA = mem[RADDR];

endmodule

// File: verif/dmurf_ctl.sv
// Model of the unit logic that drives the register file ports.
module dmurf_ctl
   import dmurf_pkg::*;
(
   input  wire logic   clk,
   output logic        ce,
   output dmurf_rreq_s rq,
   output dmurf_wreq_s wq,
   output logic        inh
);
   timeunit 1ns;
   timeprecision 1ps;
   // Ports start idle so the block never sees unknowns.
   initial
   begin
      ce = 1'b1;
      rq = '0;
      wq = '0;
      inh = 1'b0;
   end
   // Requests change at the falling edge. The read of a same-entry pair is moved one
   // entry on, unless the caller asks for the collision on purpose.
   task automatic drive(input logic c, inout dmurf_rreq_s r, input dmurf_wreq_s w,
                        input logic i, input bit col);
      @(negedge clk);
      if (r.en && w.en && r.addr == w.addr && !col)
         r.addr = r.addr + 9'h001;
      ce <= c;
      rq <= r;
      wq <= w;
      inh <= i;
   endtask
endmodule

// File: verif/tb.sv
// Directed and random bench for the 512x60 register file.
module tb
   import dmurf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        ce;
   logic        inh;
   dmurf_rreq_s rq;
   dmurf_wreq_s wq;
   logic [59:0] rd_data;
   logic        coll;
   logic [59:0] mem [DMURF_ENTRIES];
   bit          vld [DMURF_ENTRIES];
   logic [59:0] pd [2];
   bit          pk [2];
   bit          prd [2];
   bit          pcol [2];
   logic [59:0] rd_exp = 60'h0;
   bit          rd_known = 1'b1;
   int          idle = 0;
   int          err_count = 0;
   int          comparisons = 0;
   logic [59:0] d0;
   logic        c;
   // -----------------------------------
   // Clock, design and far-side model
   // -----------------------------------
   always #20 clk = ~clk;
   dmurf_top DUT (.CLK(clk), .SYS_RST(sys_rst), .CE(ce), .RD_EN(rq.en), .RD_ADDR(rq.addr),
      .WR_EN(wq.en), .WR_ADDR(wq.addr), .WR_DATA(wq.data), .ARRAY_WR_INHIBIT(inh),
      .RD_DATA(rd_data), .COLLISION(coll));
   dmurf_ctl PRT (.clk(clk), .ce(ce), .rq(rq), .wq(wq), .inh(inh));
   // A request only acts when clocked in and not inhibited.
   function automatic bit fires(input logic c, input logic en, input logic i);
      return c && en && !i;
   endfunction
   // Compares count every check and report a mismatch at once.
   task automatic cmp_data(input logic [59:0] got, input logic [59:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_flag(input logic got, input logic exp);
      cmp_data(60'(got), 60'(exp));
   endtask
   // Outputs lag a capture by one edge, so each step checks the request of two
   // steps back; entries hit by a collision are unknown until written again.
   task automatic step(input logic c, input dmurf_rreq_s r, input dmurf_wreq_s w,
                       input logic i, input bit col);
      bit rf;
      bit wf;
      PRT.drive(c, r, w, i, col);
      if (prd[1])
      begin
         rd_exp = pd[1];
         rd_known = pk[1] && !pcol[1];
      end
      cmp_flag(coll, pcol[1]);
      if (rd_known)
         cmp_data(rd_data, rd_exp);
      rf = fires(c, r.en, i);
      wf = fires(c, w.en, i);
      prd[1] = prd[0];
      pd[1] = pd[0];
      pk[1] = pk[0];
      pcol[1] = pcol[0];
      prd[0] = rf;
      pd[0] = mem[r.addr];
      pk[0] = vld[r.addr];
      pcol[0] = rf && wf && r.addr == w.addr;
      if (wf)
      begin
         mem[w.addr] = w.data;
         vld[w.addr] = !pcol[0];
      end
      idle = (rf || wf) ? 0 : idle + 1;
   endtask
   task automatic print_verdict();
      $display("Comparisons %0d, errors %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Corner cases first, then random traffic; the clock enable only drops
   // after two quiet steps so no result is frozen in flight.
   initial
   begin
      void'($urandom(28428));
      d0 = 60'({$urandom, $urandom});
      repeat (2) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      step(1'b1, 10'h000, {1'b1, 9'h000, d0}, 1'b0, 1'b0);
      step(1'b1, {1'b1, 9'h000}, {1'b1, 9'h1FF, ~d0}, 1'b0, 1'b0);
      step(1'b1, {1'b1, 9'h1FF}, 70'h0, 1'b0, 1'b0);
      step(1'b1, {1'b1, 9'h000}, {1'b1, 9'h000, ~d0}, 1'b1, 1'b0);
      step(1'b1, {1'b1, 9'h000}, {1'b1, 9'h005, d0}, 1'b0, 1'b0);
      step(1'b1, {1'b1, 9'h005}, {1'b1, 9'h005, ~d0}, 1'b0, 1'b1);
      step(1'b1, {1'b1, 9'h00A}, {1'b1, 9'h00A, d0}, 1'b1, 1'b1);
      repeat (2000)
      begin
         c = (idle >= 2) ? ($urandom_range(3) != 0) : 1'b1;
         step(c, {1'($urandom_range(1)), 9'($urandom_range(63))},
              {1'($urandom_range(1)), 9'($urandom_range(63)), 60'({$urandom, $urandom})},
              $urandom_range(7) == 0, $urandom_range(15) == 0);
      end
      repeat (2) step(1'b1, 10'h000, 70'h0, 1'b0, 1'b0);
      print_verdict();
   end
endmodule
